// ### inc/tbst_pkg.sv
/*
 * Constants for the 10BASE-Te control and self-test register slice:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// What this block does
// - Bit 13 of the 10BASE-Te register lowers the receive threshold when set.
// - Bits 12:9 pick the squelch level, 200mV plus 50mV a step, reset 0000.
// - Bit 7 set to one stops normal link pulses; it resets to zero.
// - Bit 4 reads the inverted-polarity flag and mirrors status bit 12.
// - Reading the 10BASE-Te register clears the flag and its mirror.
// - Bit 0 set disables the jabber function, for 10BASE-Te only.
// - Bits 15:8 of the first self-test register count errored bytes.
// - Writing one to bit 15 freezes the count and clears the counter.
// - With counter mode zero the error counter stops at 0xff.
// - Bits 7:0 of the first self-test register set the gap, reset 0x7d.
// - Bits 10:0 of the second self-test register set length, reset 0x5ee.
package tbst_pkg;

	localparam logic [7:0]  TENBASE_IDX      = 8'h1a;
	localparam logic [7:0]  SELFTEST_EG_IDX  = 8'h1b;
	localparam logic [7:0]  SELFTEST_LEN_IDX = 8'h1c;
	localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h20;
	localparam logic [7:0]  IRQ_MASK_IDX     = 8'h21;

	localparam int          THRESH_BIT  = 13;
	localparam int          SQUELCH_LSB = 9;
	localparam int          NLP_BIT     = 7;
	localparam int          POL_BIT     = 4;
	localparam int          JABBER_BIT  = 0;
	localparam int          ERRCNT_LSB  = 8;
	localparam int          LOCK_BIT    = 15;

	localparam logic [3:0]  SQUELCH_RST = 4'h0;
	localparam logic [7:0]  GAP_RST     = 8'h7d;
	localparam logic [10:0] LEN_RST     = 11'h5ee;
	localparam logic [7:0]  ERR_MAX     = 8'hff;

	localparam int          IRQ_POL_BIT = 0;
	localparam int          IRQ_SAT_BIT = 1;

	localparam logic [1:0]  ACK_LATENCY = 2'h1;

endpackage

// ### logic/errcount.sv
/*
 * Errored-byte counter of the self-test checker, with saturation and a
 * lock that freezes the value for software and restarts the count.
 * Assumes one clock; lock and error pulses are one cycle long.
 */
`timescale 1ns/10ps
`default_nettype none

module errcount
	import tbst_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       err_byte,
	input  wire logic       sat_mode_n,
	input  wire logic       lock,
	output logic [7:0]      locked_q,
	output logic            sat_hit_q
);

	logic [7:0] run_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			run_q <= 8'h00;
		else if (lock)
			run_q <= 8'h00;
		else if (err_byte && !(sat_mode_n == 1'b0 && run_q == ERR_MAX))
			run_q <= run_q + 8'h01;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			locked_q <= 8'h00;
		else if (lock)
			locked_q <= run_q;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sat_hit_q <= 1'b0;
		else
			sat_hit_q <= err_byte && !sat_mode_n && run_q == ERR_MAX;
	end

	sat_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		(run_q == ERR_MAX && !sat_mode_n && !lock) |=> run_q == ERR_MAX)
		else $error("saturated counter moved");
	lock_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		lock |=> run_q == 8'h00 && locked_q == $past(run_q))
		else $error("lock did not freeze and clear");

endmodule

`default_nettype wire

// ### logic/tbst_regs.sv
/*
 * Register slice for 10BASE-Te receive/transmit controls and the self-test
 * generator and checker settings, as a classic Wishbone slave.
 * Assumes a single 50 MHz clock and a master that holds its request until
 * ack; answer comes one cycle after the request is seen.
 */
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module tbst_regs
	import tbst_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        pol_inverted,
	input  wire logic        err_byte,
	input  wire logic        errcnt_mode,
	input  wire logic        status_rd,
	output logic             low_thresh_q,
	output logic [3:0]       squelch_q,
	output logic             nlp_off_q,
	output logic             jabber_off_q,
	output logic             pol_mirror_q,
	output logic [7:0]       gap_q,
	output logic [10:0]      pkt_len_q,
	output logic             irq_q
);
	import tbst_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic        req;
	logic        hit_ten;
	logic        hit_eg;
	logic        hit_len;
	logic        hit_ist;
	logic        hit_imk;
	logic        mapped;
	logic        wr;
	logic        rd;
	logic        pol_q;
	logic        lock;
	logic [7:0]  locked_cnt;
	logic        sat_hit;
	logic [1:0]  ist_q;
	logic [1:0]  imk_q;
	logic        pol_rise_q;
	logic [31:0] rdata_d;

	function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
		hit = a[9:2] == idx && a[1:0] == 2'h0;
	endfunction

	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit_ten = hit(wb_adr_i, TENBASE_IDX);
	assign hit_eg  = hit(wb_adr_i, SELFTEST_EG_IDX);
	assign hit_len = hit(wb_adr_i, SELFTEST_LEN_IDX);
	assign hit_ist = hit(wb_adr_i, IRQ_STATUS_IDX);
	assign hit_imk = hit(wb_adr_i, IRQ_MASK_IDX);
	assign mapped  = hit_ten | hit_eg | hit_len | hit_ist | hit_imk;
	assign wr      = req && mapped && wb_we_i;
	assign rd      = req && mapped && !wb_we_i;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= req && mapped;
			wb_err_o <= req && !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 10BASE-Te control bits
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_thresh_q <= 1'b0;
			squelch_q    <= SQUELCH_RST;
			nlp_off_q    <= 1'b0;
			jabber_off_q <= 1'b0;
		end
		else if (wr && hit_ten)
		begin
			if (wb_sel_i[1])
			begin
				low_thresh_q <= wb_dat_i[THRESH_BIT];
				squelch_q    <= wb_dat_i[SQUELCH_LSB+3:SQUELCH_LSB];
			end
			if (wb_sel_i[0])
			begin
				nlp_off_q    <= wb_dat_i[NLP_BIT];
				jabber_off_q <= wb_dat_i[JABBER_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gap_q     <= GAP_RST;
			pkt_len_q <= LEN_RST;
		end
		else
		begin
			if (wr && hit_eg && wb_sel_i[0])
				gap_q <= wb_dat_i[7:0];
			if (wr && hit_len && wb_sel_i[0])
				pkt_len_q[7:0] <= wb_dat_i[7:0];
			if (wr && hit_len && wb_sel_i[1])
				pkt_len_q[10:8] <= wb_dat_i[10:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// polarity flag, set wins over the read clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pol_q <= 1'b0;
		else if (pol_inverted)
			pol_q <= 1'b1;
		else if (rd && hit_ten)
			pol_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pol_mirror_q <= 1'b0;
		else if (pol_inverted)
			pol_mirror_q <= 1'b1;
		else if (rd && hit_ten)
			pol_mirror_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// lock on a one written to bit 15
	assign lock = wr && hit_eg && wb_sel_i[1] && wb_dat_i[LOCK_BIT];

	errcount u_errcount (
		.clk        (clk),
		.rstn       (rstn),
		.err_byte   (err_byte),
		.sat_mode_n (errcnt_mode),
		.lock       (lock),
		.locked_q   (locked_cnt),
		.sat_hit_q  (sat_hit)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: polarity went inverted, counter saturated.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pol_rise_q <= 1'b0;
		else
			pol_rise_q <= pol_inverted;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ist_q <= 2'h0;
		else
		begin
			ist_q[IRQ_POL_BIT] <= (pol_inverted && !pol_rise_q)
				|| (ist_q[IRQ_POL_BIT] && !(wr && hit_ist && wb_sel_i[0]
				&& wb_dat_i[IRQ_POL_BIT]));
			ist_q[IRQ_SAT_BIT] <= sat_hit
				|| (ist_q[IRQ_SAT_BIT] && !(wr && hit_ist && wb_sel_i[0]
				&& wb_dat_i[IRQ_SAT_BIT]));
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			imk_q <= 2'h0;
		else if (wr && hit_imk && wb_sel_i[0])
			imk_q <= wb_dat_i[1:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= |(ist_q & imk_q);
	end

	////////////////////////////////////////////////////////////////////////
	// read mux, reserved bits zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (hit_ten)
		begin
			rdata_d[THRESH_BIT]                    = low_thresh_q;
			rdata_d[SQUELCH_LSB+3:SQUELCH_LSB]     = squelch_q;
			rdata_d[NLP_BIT]                       = nlp_off_q;
			rdata_d[POL_BIT]                       = pol_q;
			rdata_d[JABBER_BIT]                    = jabber_off_q;
		end
		else if (hit_eg)
			rdata_d[15:0] = {locked_cnt, gap_q};
		else if (hit_len)
			rdata_d[10:0] = pkt_len_q;
		else if (hit_ist)
			rdata_d[1:0] = ist_q;
		else if (hit_imk)
			rdata_d[1:0] = imk_q;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wb_dat_o <= 32'h0000_0000;
		else if (rd)
			wb_dat_o <= rdata_d;
	end

	////////////////////////////////////////////////////////////////////////
	sequence ten_read_s;
		rd && hit_ten && !pol_inverted;
	endsequence

	read_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		ten_read_s |=> !pol_q && !pol_mirror_q)
		else $error("read did not clear polarity flag");
	status_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		(pol_q && status_rd && !(rd && hit_ten)) |=> pol_q)
		else $error("status read cleared flag");
	mirror_equal_a: assert property (@(posedge clk) disable iff (!rstn)
		pol_q == pol_mirror_q)
		else $error("mirror differs from flag");
	pol_read_a: assert property (@(posedge clk) disable iff (!rstn)
		(rd && hit_ten) |=> wb_dat_o[POL_BIT] == $past(pol_q))
		else $error("polarity bit read wrong");
	squelch_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_ten && wb_sel_i[1])
		|=> squelch_q == $past(wb_dat_i[12:9]))
		else $error("squelch not stored");
	thresh_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_ten && wb_sel_i[1])
		|=> low_thresh_q == $past(wb_dat_i[13]))
		else $error("threshold bit not stored");
	nlp_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_ten && wb_sel_i[0]) |=> nlp_off_q == $past(wb_dat_i[7]))
		else $error("link pulse bit not stored");
	jabber_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_ten && wb_sel_i[0])
		|=> jabber_off_q == $past(wb_dat_i[0]))
		else $error("jabber bit not stored");
	gap_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_eg && wb_sel_i[0]) |=> gap_q == $past(wb_dat_i[7:0]))
		else $error("gap not stored");
	len_wr_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr && hit_len && wb_sel_i == 4'h3)
		|=> pkt_len_q == $past(wb_dat_i[10:0]))
		else $error("length not stored");
	rsvd_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		(rd && hit_len) |=> wb_dat_o[31:11] == 21'h000000)
		else $error("reserved bits not zero");
	count_read_a: assert property (@(posedge clk) disable iff (!rstn)
		(rd && hit_eg) |=> wb_dat_o[15:8] == $past(locked_cnt))
		else $error("error count read wrong");
	ack_time_a: assert property (@(posedge clk) disable iff (!rstn)
		(req && mapped) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");

endmodule

`default_nettype wire

// ### tb/tenbase_and_selftest_config_regs_test.sv
/*
 * Self-checking bench for the 10BASE-Te control and self-test register
 * slice. Assumes tbst_pkg and tbst_regs are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, b); \
	end end

module tenbase_and_selftest_config_regs_test;
	import tbst_pkg::*;

	logic        clk, rstn, cyc, stb, we, pol, eb, mode, srd;
	logic [9:0]  adr;
	logic [3:0]  sel, sq;
	logic [31:0] wdat, rdat, seed, d, last68;
	logic        ack, err, lt, nlp, jab, pm, irq;
	logic [7:0]  gap;
	logic [10:0] len;
	logic [33:0] e;
	logic [33:0] expq[$];
	int          miscompares, checks_done, i;

	tbst_regs i_tbst_regs (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.pol_inverted(pol), .err_byte(eb), .errcnt_mode(mode),
		.status_rd(srd), .low_thresh_q(lt), .squelch_q(sq),
		.nlp_off_q(nlp), .jabber_off_q(jab), .pol_mirror_q(pm),
		.gap_q(gap), .pkt_len_q(len), .irq_q(irq));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// One classic cycle; the expected answer is queued before the request.
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [31:0] dw, input logic [31:0] x, input logic er);
		int n;
		expq.push_back({~w, er, x});
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= dw;
		sel <= 4'h3;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (ack === 1'b1 || err === 1'b1)
				break;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 50)
		begin
			`CHECK(1'b1, 1'b0)
			finish_test();
		end
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge clk);
			eb <= 1'b1;
			@(posedge clk);
			eb <= 1'b0;
		end
	endtask

	task automatic done(input string s);
		repeat (2) @(posedge clk);
		$display("test %s done", s);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// The output watcher takes the oldest note for every answer.
	always @(posedge clk)
	begin
		if (ack === 1'b1 || err === 1'b1)
		begin
			if (expq.size() == 0)
				`CHECK(1'b1, 1'b0)
			else
			begin
				e = expq.pop_front();
				`CHECK(err, e[32])
				if (e[33] && !e[32])
					`CHECK(rdat, e[31:0])
			end
		end
	end

	initial
	begin
		{rstn, cyc, stb, we, pol, eb, mode, srd} = '0;
		adr = '0;
		sel = '0;
		wdat = '0;
		seed = 32'h68fd;
		miscompares = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		bus(0, 10'h68, 0, 32'h0, 0);
		bus(0, 10'h6c, 0, 32'h7d, 0);
		bus(0, 10'h70, 0, 32'h5ee, 0);
		`CHECK({gap, len}, {8'h7d, 11'h5ee})
		done("reset");
		for (i = 0; i < 16; i++)
		begin
			d = rnd();
			d[12:9] = i[3:0];
			last68 = d & 32'h3e81;
			bus(1, 10'h68, d, 0, 0);
			bus(0, 10'h68, 0, last68, 0);
			`CHECK(sq, d[12:9])
			`CHECK({lt, nlp, jab}, {d[13], d[7], d[0]})
		end
		done("controls");
		for (i = 0; i < 8; i++)
		begin
			d = rnd() & 32'hffff7fff;
			bus(1, 10'h6c, d, 0, 0);
			bus(0, 10'h6c, 0, {24'h0, d[7:0]}, 0);
			bus(1, 10'h70, d, 0, 0);
			bus(0, 10'h70, 0, d & 32'h7ff, 0);
			`CHECK(len, d[10:0])
		end
		`CHECK(gap, d[7:0])
		bus(0, 10'h3fc, 0, 0, 1);
		bus(1, 10'h69, 0, 0, 1);
		done("settings");
		@(posedge clk);
		pol <= 1'b1;
		repeat (3) @(posedge clk);
		pol <= 1'b0;
		srd <= 1'b1;
		@(posedge clk);
		srd <= 1'b0;
		repeat (2) @(posedge clk);
		`CHECK(pm, 1'b1)
		bus(0, 10'h68, 0, last68 | 32'h10, 0);
		repeat (2) @(posedge clk);
		`CHECK(pm, 1'b0)
		bus(0, 10'h68, 0, last68, 0);
		done("polarity");
		bus(1, 10'h6c, 32'h8000 | d[7:0], 0, 0);
		pulses(5);
		bus(1, 10'h6c, 32'h8000 | d[7:0], 0, 0);
		bus(0, 10'h6c, 0, {16'h0, 8'h05, d[7:0]}, 0);
		pulses(300);
		bus(1, 10'h6c, 32'h8000 | d[7:0], 0, 0);
		bus(0, 10'h6c, 0, {16'h0, 8'hff, d[7:0]}, 0);
		mode <= 1'b1;
		pulses(260);
		bus(1, 10'h6c, 32'h8000 | d[7:0], 0, 0);
		bus(0, 10'h6c, 0, {16'h0, 8'h04, d[7:0]}, 0);
		done("counter");
		bus(0, 10'h80, 0, 32'h3, 0);
		bus(0, 10'h84, 0, 32'h0, 0);
		`CHECK(irq, 1'b0)
		bus(1, 10'h84, 32'h2, 0, 0);
		repeat (2) @(posedge clk);
		`CHECK(irq, 1'b1)
		bus(1, 10'h80, 32'h2, 0, 0);
		bus(0, 10'h80, 0, 32'h1, 0);
		repeat (2) @(posedge clk);
		`CHECK(irq, 1'b0)
		bus(1, 10'h80, 32'h1, 0, 0);
		bus(0, 10'h80, 0, 32'h0, 0);
		bus(1, 10'h84, 32'h1, 0, 0);
		pol <= 1'b1;
		repeat (3) @(posedge clk);
		`CHECK(irq, 1'b1)
		pol <= 1'b0;
		bus(1, 10'h80, 32'h1, 0, 0);
		bus(0, 10'h80, 0, 32'h0, 0);
		done("interrupt");
		repeat (3) @(posedge clk);
		`CHECK(expq.size(), 0)
		finish_test();
	end
endmodule

`undef CHECK
`default_nettype wire
